// ==== verilog/dcps_pkg.sv ====
package dcps_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [15:0] PHASE_STATUS_ADDR = 16'h03f4;
   localparam logic [15:0] CMD_RESULT_DATA_ADDR = 16'h03f5;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int ST_READY_BIT = 7;
   localparam int ST_TO_HOST_BIT = 6;
   localparam int ST_EXEC_BIT = 5;
   localparam int ST_BUSY_BIT = 4;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [7:0] ST0_INVALID = 8'h80;
   // ----------------------------------------
   // Command codes, low five bits of opcode
   // ----------------------------------------
   localparam logic [4:0] OP_SPECIFY = 5'h03;
   localparam logic [4:0] OP_DRIVE_STATE = 5'h04;
   localparam logic [4:0] OP_WRITE_DATA = 5'h05;
   localparam logic [4:0] OP_READ_DATA = 5'h06;
   localparam logic [4:0] OP_RECALIBRATE = 5'h07;
   localparam logic [4:0] OP_SENSE_INT = 5'h08;
   localparam logic [4:0] OP_SEEK = 5'h0f;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int MAX_PARAMS = 8;
   localparam int MAX_RESULTS = 7;
   localparam int XFER_BYTES = 16;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MECH_TIME_NS = 2000;
   localparam int MECH_CYCLES = MECH_TIME_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      EX_INTERNAL = 2'b00,
      EX_MECH = 2'b01,
      EX_TO_HOST = 2'b10,
      EX_FROM_HOST = 2'b11
   } dcps_exec_type;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_COMMAND = 2'b01,
      PH_EXEC = 2'b10,
      PH_RESULT = 2'b11
   } dcps_phase_type;
   typedef enum logic [2:0] {
      H_POLL = 3'b000,
      H_STAT = 3'b001,
      H_RDAT = 3'b010,
      H_DMA = 3'b011,
      H_DMAR = 3'b100,
      H_GAP = 3'b101
   } dcps_host_type;
endpackage

// ==== verilog/dcps_if.sv ====
// ----------------------------------------
// I/O port bus plus DMA channel between host and controller
// ----------------------------------------
interface dcps_if;
   logic [15:0] addr;
   logic rd;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic floppy_dma_request;
   logic floppy_dma_to_mem;
   logic floppy_dma_acknowledge_n;
   modport dev (
      input addr, rd, wr, wdata, floppy_dma_acknowledge_n,
      output rdata, floppy_dma_request, floppy_dma_to_mem
   );
   modport host (
      output addr, rd, wr, wdata, floppy_dma_acknowledge_n,
      input rdata, floppy_dma_request, floppy_dma_to_mem
   );
endinterface

// ==== verilog/dcps_device.sv ====
module dcps_device #(
   parameter int XFER_BYTES = dcps_pkg::XFER_BYTES,
   parameter int MECH_CYCLES = dcps_pkg::MECH_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   dcps_if.dev bus,
   output logic [1:0] phase_o,
   output logic cmd_done_o
);
   // ----------------------------------------
   // Command table lookups
   // ----------------------------------------
   function automatic logic [3:0] param_count(input logic [4:0] op);
      case (op)
         dcps_pkg::OP_READ_DATA, dcps_pkg::OP_WRITE_DATA: param_count = 4'd8;
         dcps_pkg::OP_SPECIFY, dcps_pkg::OP_SEEK: param_count = 4'd2;
         dcps_pkg::OP_RECALIBRATE, dcps_pkg::OP_DRIVE_STATE: param_count = 4'd1;
         default: param_count = 4'd0;
      endcase
   endfunction

   function automatic logic [3:0] result_count(input logic [4:0] op);
      case (op)
         dcps_pkg::OP_READ_DATA, dcps_pkg::OP_WRITE_DATA: result_count = 4'd7;
         dcps_pkg::OP_SENSE_INT: result_count = 4'd2;
         dcps_pkg::OP_SPECIFY, dcps_pkg::OP_SEEK: result_count = 4'd0;
         dcps_pkg::OP_RECALIBRATE: result_count = 4'd0;
         default: result_count = 4'd1; // Drive state and invalid codes
      endcase
   endfunction

   function automatic dcps_pkg::dcps_exec_type exec_kind(input logic [4:0] op);
      case (op)
         dcps_pkg::OP_READ_DATA: exec_kind = dcps_pkg::EX_TO_HOST;
         dcps_pkg::OP_WRITE_DATA: exec_kind = dcps_pkg::EX_FROM_HOST;
         dcps_pkg::OP_SEEK, dcps_pkg::OP_RECALIBRATE: exec_kind = dcps_pkg::EX_MECH;
         default: exec_kind = dcps_pkg::EX_INTERNAL;
      endcase
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   dcps_pkg::dcps_phase_type ph_r, ph_nxt;
   logic [7:0] opc_r, opc_nxt;
   logic [7:0] par_r [dcps_pkg::MAX_PARAMS], par_nxt [dcps_pkg::MAX_PARAMS];
   logic [3:0] idx_r, idx_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [7:0] sum_r, sum_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic req_r, req_nxt;
   logic done_r, done_nxt;
   logic dir_r, dir_nxt;
   logic sel_stat, sel_data, dma_hit;
   logic [7:0] status;
   dcps_pkg::dcps_exec_type kind;

   assign sel_stat = (bus.addr == dcps_pkg::PHASE_STATUS_ADDR);
   assign sel_data = (bus.addr == dcps_pkg::CMD_RESULT_DATA_ADDR);
   assign dma_hit = req_r && !bus.floppy_dma_acknowledge_n;
   assign kind = exec_kind(opc_r[4:0]);

   // Ready and direction for host pacing
   always_comb begin
      status = 8'h00;
      status[dcps_pkg::ST_READY_BIT] = (ph_r != dcps_pkg::PH_EXEC);
      status[dcps_pkg::ST_TO_HOST_BIT] = (ph_r == dcps_pkg::PH_RESULT);
      status[dcps_pkg::ST_EXEC_BIT] = (ph_r == dcps_pkg::PH_EXEC);
      status[dcps_pkg::ST_BUSY_BIT] = (ph_r != dcps_pkg::PH_IDLE);
   end

   // ----------------------------------------
   // Phase sequencer next state
   // ----------------------------------------
   always_comb begin
      ph_nxt = ph_r;
      opc_nxt = opc_r;
      par_nxt = par_r;
      idx_nxt = idx_r;
      cnt_nxt = cnt_r;
      sum_nxt = sum_r;
      rdata_nxt = rdata_r;
      req_nxt = 1'b0;
      done_nxt = 1'b0;
      if (bus.rd && sel_stat) begin
         rdata_nxt = status;
      end
      case (ph_r)
         dcps_pkg::PH_IDLE: begin
            // Stays here until the host writes an opcode
            if (bus.wr && sel_data) begin
               opc_nxt = bus.wdata;
               idx_nxt = 4'd0;
               sum_nxt = 8'h00;
               if (param_count(bus.wdata[4:0]) == 4'd0) begin
                  ph_nxt = dcps_pkg::PH_EXEC;
                  cnt_nxt = 16'd0;
               end else begin
                  ph_nxt = dcps_pkg::PH_COMMAND;
               end
            end
         end
         dcps_pkg::PH_COMMAND: begin
            if (bus.wr && sel_data) begin
               par_nxt[idx_r[2:0]] = bus.wdata;
               idx_nxt = idx_r + 4'd1;
               if (idx_r + 4'd1 == param_count(opc_r[4:0])) begin
                  // No extra host action needed to start
                  ph_nxt = dcps_pkg::PH_EXEC;
                  cnt_nxt = 16'd0;
               end
            end
         end
         dcps_pkg::PH_EXEC: begin
            case (kind)
               dcps_pkg::EX_TO_HOST, dcps_pkg::EX_FROM_HOST: begin
                  // Request dropped a cycle after each acknowledge
                  req_nxt = !dma_hit && (cnt_r < 16'(XFER_BYTES));
                  if (dma_hit) begin
                     cnt_nxt = cnt_r + 16'd1;
                     if (kind == dcps_pkg::EX_TO_HOST && bus.rd) begin
                        rdata_nxt = cnt_r[7:0] ^ par_r[1];
                     end
                     if (kind == dcps_pkg::EX_FROM_HOST && bus.wr) begin
                        sum_nxt = sum_r ^ bus.wdata;
                     end
                  end
               end
               dcps_pkg::EX_MECH: begin
                  cnt_nxt = cnt_r + 16'd1;
               end
               default: begin
                  cnt_nxt = cnt_r;
               end
            endcase
            if ((kind == dcps_pkg::EX_INTERNAL)
                || (kind == dcps_pkg::EX_MECH && cnt_r == 16'(MECH_CYCLES - 1))
                || (kind[1] && cnt_r == 16'(XFER_BYTES))) begin
               idx_nxt = 4'd0;
               if (result_count(opc_r[4:0]) == 4'd0) begin
                  ph_nxt = dcps_pkg::PH_IDLE;
                  done_nxt = 1'b1;
               end else begin
                  ph_nxt = dcps_pkg::PH_RESULT;
               end
            end
         end
         dcps_pkg::PH_RESULT: begin
            if (bus.rd && sel_data) begin
               // First byte reports the command, second the data check
               if (idx_r == 4'd0) begin
                  rdata_nxt = (param_count(opc_r[4:0]) == 4'd0
                               && result_count(opc_r[4:0]) == 4'd1
                               && opc_r[4:0] != dcps_pkg::OP_DRIVE_STATE)
                              ? dcps_pkg::ST0_INVALID : {3'b000, opc_r[4:0]};
               end else if (idx_r == 4'd1) begin
                  rdata_nxt = sum_r;
               end else begin
                  rdata_nxt = par_r[idx_r[2:0]];
               end
               idx_nxt = idx_r + 4'd1;
               if (idx_r + 4'd1 == result_count(opc_r[4:0])) begin
                  ph_nxt = dcps_pkg::PH_IDLE;
                  done_nxt = 1'b1;
               end
            end
         end
         default: begin
            ph_nxt = dcps_pkg::PH_IDLE;
         end
      endcase
      // Direction follows the opcode, so it is steady before any request
      dir_nxt = (opc_nxt[4:0] == dcps_pkg::OP_READ_DATA);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph_r <= dcps_pkg::PH_IDLE;
         opc_r <= 8'h00;
         for (int i = 0; i < dcps_pkg::MAX_PARAMS; i++) begin
            par_r[i] <= 8'h00;
         end
         idx_r <= 4'd0;
         cnt_r <= 16'd0;
         sum_r <= 8'h00;
         rdata_r <= 8'h00;
         req_r <= 1'b0;
         done_r <= 1'b0;
         dir_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         opc_r <= opc_nxt;
         par_r <= par_nxt;
         idx_r <= idx_nxt;
         cnt_r <= cnt_nxt;
         sum_r <= sum_nxt;
         rdata_r <= rdata_nxt;
         req_r <= req_nxt;
         done_r <= done_nxt;
         dir_r <= dir_nxt;
      end
   end

   // Outputs straight from flops
   assign bus.rdata = rdata_r;
   assign bus.floppy_dma_request = req_r;
   assign bus.floppy_dma_to_mem = dir_r;
   assign phase_o = ph_r;
   assign cmd_done_o = done_r;
endmodule

// ==== verilog/dcps_host.sv ====
module dcps_host (
   input wire logic clk_i,
   input wire logic rst_n_i,
   dcps_if.host bus,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_byte_i,
   input wire logic [7:0] dma_wdata_i,
   output logic cmd_taken_o,
   output logic [7:0] result_o,
   output logic result_valid_o,
   output logic [7:0] dma_data_o,
   output logic dma_valid_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   dcps_pkg::dcps_host_type st_r, st_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt, ack_n_r, ack_n_nxt;
   logic [7:0] wdata_r, wdata_nxt, res_r, res_nxt, dma_r, dma_nxt;
   logic taken_r, taken_nxt, resv_r, resv_nxt, dmav_r, dmav_nxt;
   logic dma_d_r, dma_d_nxt, res_d_r, res_d_nxt;

   // ----------------------------------------
   // Poll, transfer and DMA service
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      ack_n_nxt = 1'b1;
      wdata_nxt = wdata_r;
      res_nxt = res_r;
      dma_nxt = dma_r;
      taken_nxt = 1'b0;
      resv_nxt = 1'b0;
      dmav_nxt = 1'b0;
      case (st_r)
         dcps_pkg::H_POLL: begin
            if (bus.floppy_dma_request) begin
               ack_n_nxt = 1'b0;
               rd_nxt = bus.floppy_dma_to_mem;
               wr_nxt = !bus.floppy_dma_to_mem;
               wdata_nxt = dma_wdata_i;
               // Both directions wait out the ack; stale status is never judged
               st_nxt = dcps_pkg::H_DMA;
            end else begin
               // Status read precedes every command or result byte
               addr_nxt = dcps_pkg::PHASE_STATUS_ADDR;
               rd_nxt = 1'b1;
               st_nxt = dcps_pkg::H_STAT;
            end
         end
         dcps_pkg::H_STAT: begin
            st_nxt = dcps_pkg::H_GAP;
         end
         dcps_pkg::H_GAP: begin
            // Status byte valid now; act on ready and direction
            st_nxt = dcps_pkg::H_POLL;
            if (bus.rdata[dcps_pkg::ST_READY_BIT]) begin
               if (bus.rdata[dcps_pkg::ST_TO_HOST_BIT]) begin
                  addr_nxt = dcps_pkg::CMD_RESULT_DATA_ADDR;
                  rd_nxt = 1'b1;
                  st_nxt = dcps_pkg::H_RDAT;
               end else if (cmd_valid_i) begin
                  addr_nxt = dcps_pkg::CMD_RESULT_DATA_ADDR;
                  wr_nxt = 1'b1;
                  wdata_nxt = cmd_byte_i;
                  taken_nxt = 1'b1;
                  st_nxt = dcps_pkg::H_DMAR;
               end
            end
         end
         dcps_pkg::H_RDAT: begin
            st_nxt = dcps_pkg::H_DMAR;
         end
         dcps_pkg::H_DMA: begin
            st_nxt = dcps_pkg::H_DMAR;
         end
         dcps_pkg::H_DMAR: begin
            // Data from a read strobe is valid here
            st_nxt = dcps_pkg::H_POLL;
         end
         default: begin
            st_nxt = dcps_pkg::H_POLL;
         end
      endcase
      // Read data stands the cycle after the strobe, so capture runs one late
      dma_d_nxt = rd_r && !ack_n_r;
      res_d_nxt = rd_r && ack_n_r && addr_r == dcps_pkg::CMD_RESULT_DATA_ADDR;
      res_nxt = res_d_r ? bus.rdata : res_r;
      dma_nxt = dma_d_r ? bus.rdata : dma_r;
      resv_nxt = res_d_r;
      dmav_nxt = dma_d_r;
   end

   // Registers only; every decision is made above
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= dcps_pkg::H_POLL;
         addr_r <= 16'h0000;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         ack_n_r <= 1'b1;
         wdata_r <= 8'h00;
         res_r <= 8'h00;
         dma_r <= 8'h00;
         taken_r <= 1'b0;
         resv_r <= 1'b0;
         dmav_r <= 1'b0;
         dma_d_r <= 1'b0;
         res_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         ack_n_r <= ack_n_nxt;
         wdata_r <= wdata_nxt;
         taken_r <= taken_nxt;
         dma_d_r <= dma_d_nxt;
         res_d_r <= res_d_nxt;
         res_r <= res_nxt;
         resv_r <= resv_nxt;
         dma_r <= dma_nxt;
         dmav_r <= dmav_nxt;
      end
   end

   assign bus.addr = addr_r;
   assign bus.rd = rd_r;
   assign bus.wr = wr_r;
   assign bus.wdata = wdata_r;
   assign bus.floppy_dma_acknowledge_n = ack_n_r;
   assign cmd_taken_o = taken_r;
   assign result_o = res_r;
   assign result_valid_o = resv_r;
   assign dma_data_o = dma_r;
   assign dma_valid_o = dmav_r;
endmodule

// ==== test/dcps_sva.sv ====
module dcps_sva (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [15:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] rdata,
   input wire logic floppy_dma_request,
   input wire logic floppy_dma_to_mem,
   input wire logic floppy_dma_acknowledge_n
);
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   logic st_rd;
   logic dat_acc;
   logic polled_r;
   logic polled_nxt;
   logic st_pend_r;
   logic st_pend_nxt;
   logic [7:0] last_st_r;
   logic [7:0] last_st_nxt;
   // Plain accesses only, DMA cycles carry no address meaning
   assign st_rd = rd && floppy_dma_acknowledge_n && addr == dcps_pkg::PHASE_STATUS_ADDR;
   assign dat_acc = (rd || wr) && floppy_dma_acknowledge_n
      && addr == dcps_pkg::CMD_RESULT_DATA_ADDR;
   // Remember poll and the status value it returned
   always_comb begin
      polled_nxt = st_rd ? 1'b1 : (dat_acc ? 1'b0 : polled_r);
      st_pend_nxt = st_rd;
      last_st_nxt = st_pend_r ? rdata : last_st_r;
   end
   // Registers of the helper
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         polled_r <= 1'b0;
         st_pend_r <= 1'b0;
         last_st_r <= 8'h00;
      end else begin
         polled_r <= polled_nxt;
         st_pend_r <= st_pend_nxt;
         last_st_r <= last_st_nxt;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   req_drop_a:
      assert property (floppy_dma_request && !floppy_dma_acknowledge_n |=> !floppy_dma_request)
         else $error("dma request held after acknowledge");
   ack_needs_req_a:
      assert property (!floppy_dma_acknowledge_n |-> floppy_dma_request)
         else $error("acknowledge without request");
   ack_strobe_a:
      assert property (!floppy_dma_acknowledge_n |-> (floppy_dma_to_mem ? rd && !wr : wr && !rd))
         else $error("acknowledge with wrong strobe");
   ack_pulse_a:
      assert property ($fell(floppy_dma_acknowledge_n) |=> floppy_dma_acknowledge_n)
         else $error("acknowledge longer than one cycle");
   dir_stable_a:
      assert property (floppy_dma_request |=> !floppy_dma_request || $stable(floppy_dma_to_mem))
         else $error("direction moved during request");
   poll_first_a:
      assert property (dat_acc |-> polled_r)
         else $error("data access without status poll");
   write_dir_a:
      assert property (wr && dat_acc |-> last_st_r[7] && !last_st_r[6])
         else $error("data write against status direction");
   read_dir_a:
      assert property (rd && dat_acc |-> last_st_r[7] && last_st_r[6])
         else $error("data read against status direction");
   status_sane_a:
      assert property (st_pend_r |-> !(rdata[7] && rdata[5]))
         else $error("status ready during execution");
endmodule

// ==== test/diskette_command_phase_sequencer_test.sv ====
module diskette_command_phase_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Small counts keep the run short
   localparam int XFER = 5;
   localparam int MECH = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic [7:0] cmd_byte_i = 8'h00;
   logic [7:0] dma_wdata_i = 8'ha7;
   logic cmd_taken_o;
   logic result_valid_o;
   logic dma_valid_o;
   logic cmd_done_o;
   logic [7:0] result_o;
   logic [7:0] dma_data_o;
   logic [1:0] phase_o;
   logic [1:0] last_ph = 2'h0;
   int err_total = 0;
   int checks_done = 0;
   int exec_cnt = 0;
   int ack_cnt = 0;
   logic [7:0] res_q[$];
   logic [7:0] dma_q[$];
   dcps_if bus_if ();
   dcps_device #(.XFER_BYTES(XFER), .MECH_CYCLES(MECH)) u_dcps_device (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .bus(bus_if.dev), .phase_o(phase_o), .cmd_done_o(cmd_done_o));
   dcps_host u_dcps_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if.host),
      .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .dma_wdata_i(dma_wdata_i),
      .cmd_taken_o(cmd_taken_o), .result_o(result_o), .result_valid_o(result_valid_o),
      .dma_data_o(dma_data_o), .dma_valid_o(dma_valid_o));
   dcps_sva u_dcps_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(bus_if.addr), .rd(bus_if.rd),
      .wr(bus_if.wr), .rdata(bus_if.rdata), .floppy_dma_request(bus_if.floppy_dma_request),
      .floppy_dma_to_mem(bus_if.floppy_dma_to_mem),
      .floppy_dma_acknowledge_n(bus_if.floppy_dma_acknowledge_n));
   // ----------------------------------------
   // Clock, compare and verdict
   // ----------------------------------------
   always #5 clk_i = ~clk_i;
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic ok_step(input logic [1:0] p, input logic [1:0] c);
      return (p == 2'h0 && c inside {2'h1, 2'h2}) || (p == 2'h1 && c == 2'h2)
         || (p == 2'h2 && c inside {2'h3, 2'h0}) || (p == 2'h3 && c == 2'h0);
   endfunction
   // Phase watcher and collectors; pre-edge values, so no race with the design
   always @(posedge clk_i) begin
      if (rst_n_i === 1'b1 && phase_o !== last_ph) begin
         check("phase step", 1, ok_step(last_ph, phase_o));
      end
      last_ph <= phase_o;
      if (phase_o === 2'h2) begin
         exec_cnt <= exec_cnt + 1;
      end
      if (bus_if.floppy_dma_acknowledge_n === 1'b0) begin
         ack_cnt <= ack_cnt + 1;
      end
      if (result_valid_o === 1'b1) begin
         res_q.push_back(result_o);
      end
      if (dma_valid_o === 1'b1) begin
         dma_q.push_back(dma_data_o);
      end
   end
   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic send_byte(input logic [7:0] b);
      int n;
      cmd_valid_i <= 1'b1;
      cmd_byte_i <= b;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cmd_taken_o !== 1'b1 && n < 500);
      check("byte taken", 1, cmd_taken_o);
   endtask
   // One whole command; counters cleared while idle so the watcher cannot clash
   task automatic run_cmd(input logic [7:0] op, input int np, input logic [7:0] pv,
         input int nres, input logic [7:0] b0, input int mn, input int mx);
      int n;
      res_q.delete();
      dma_q.delete();
      exec_cnt = 0;
      ack_cnt = 0;
      send_byte(op);
      for (int i = 0; i < np; i++) begin
         send_byte(pv);
      end
      cmd_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cmd_done_o !== 1'b1 && n < 3000);
      repeat (4) @(posedge clk_i);
      check("done seen", 1, n < 3000);
      check("result count", nres, res_q.size());
      if (nres > 0) check("result 0", b0, res_q[0]);
      for (int i = 2; i < nres; i++) begin
         check("param echo", pv, res_q[i]);
      end
      if (op inside {8'h05, 8'h06}) begin
         check("xor sum", op == 8'h05 ? 8'ha7 : 8'h00, res_q[1]);
      end
      check("ack count", op inside {8'h05, 8'h06} ? XFER : 0, ack_cnt);
      check("dma count", op == 8'h06 ? XFER : 0, dma_q.size());
      foreach (dma_q[i]) check("dma byte", i ^ pv, dma_q[i]);
      if (mn > 0) check("exec span", 1, exec_cnt >= mn && exec_cnt <= mx);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_idle;
      check("idle phase", 0, phase_o);
      check("idle ack", 1, bus_if.floppy_dma_acknowledge_n);
      repeat (20) @(posedge clk_i);
      check("idle hold", 0, phase_o);
      check("idle results", 0, res_q.size());
   endtask
   // Back to back, each started four cycles after the last is done
   task automatic t_no_result;
      run_cmd(8'h0f, 2, 8'h21, 0, 8'h00, MECH, 40);
      run_cmd(8'h07, 1, 8'h00, 0, 8'h00, MECH, 40);
      run_cmd(8'h03, 2, 8'h4b, 0, 8'h00, 1, 2);
   endtask
   task automatic t_results;
      run_cmd(8'h08, 0, 8'h00, 2, 8'h08, 1, 2);
      run_cmd(8'h04, 1, 8'h01, 1, 8'h04, 1, 40);
      run_cmd(8'h01, 0, 8'h00, 1, 8'h80, 0, 0);
   endtask
   task automatic t_dma;
      run_cmd(8'h06, 8, 8'h5a, 7, 8'h06, XFER, 400);
      run_cmd(8'h05, 8, 8'h3c, 7, 8'h05, XFER, 400);
   endtask
   // Reset lands in mid transfer; the next command must still run
   task automatic t_reset_mid;
      int n;
      send_byte(8'h06);
      repeat (8) send_byte(8'h11);
      cmd_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (bus_if.floppy_dma_request !== 1'b1 && n < 200);
      check("request up", 1, bus_if.floppy_dma_request);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("reset phase", 0, phase_o);
      check("reset request", 0, bus_if.floppy_dma_request);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      run_cmd(8'h08, 0, 8'h00, 2, 8'h08, 1, 2);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_idle;
      t_no_result;
      t_results;
      t_dma;
      t_reset_mid;
      summarize;
   end
   // Whole run needs well under a thousand cycles; this allows 20,000
   initial begin
      #200_000;
      err_total++;
      summarize;
   end
endmodule
